// *** src/pin_router_pkg.sv ***
// Purpose: Constants, carriers and helpers for the multifunction pin router
// Assumes: One clock, synchronous active-low global reset
// Notes: Tags below mark the logic for each rule
// Operation
// - Terminal 6: clock-run request or IRQ2..IRQ15
// - Terminal 5: gpio4, IRQs, audio, LEDs, event
// - Terminal 4: gpio3, IRQs, audio, ring, LED, event
// - Terminal 3: serial IRQ or IRQ4..15, reset 0001
// - Terminal 2: gpio2, DMA request, IRQs, test_observe_mux
// - Terminal 1: gpio1, INTB, IRQs, audio, LEDs
// - Terminal 0: gpio0, INTA, IRQs, audio, LEDs
// - Routing bits 31..28 read zero, ignore writes
// - Select fields reset only on global reset
// - Routing value may preload from serial EEPROM
// - Input-routed level visible, change sets status
// - Output-routed terminal drives general output bit
package pin_router_pkg;

	localparam int          TERMINALS      = 7;
	localparam int          GP_BITS        = 5;
	localparam int          SEL_W          = 4;

	localparam logic [7:0]  ROUTE_OFFSET   = 8'h8c;
	localparam logic [7:0]  GPI_DATA_OFFSET = 8'h80;
	localparam logic [7:0]  GPI_STS_OFFSET = 8'h84;
	localparam logic [7:0]  GPO_OFFSET     = 8'h88;

	localparam logic [31:0] ROUTE_RESET    = 32'h0000_1000;
	localparam logic [31:0] ROUTE_WR_MASK  = 32'h0fff_ffff;
	localparam logic [4:0]  GPO_RESET      = 5'h00;
	localparam logic [4:0]  GPI_STS_RESET  = 5'h00;

	localparam logic [3:0]  CODE_GP_IN     = 4'h0;
	localparam logic [3:0]  CODE_GP_OUT    = 4'h1;

	// Codes that drive the terminal, one bit per code
	localparam logic [15:0] DRIVE_MASK_6   = 16'hfffe;
	localparam logic [15:0] DRIVE_MASK_5   = 16'hf732;
	localparam logic [15:0] DRIVE_MASK_4   = 16'hfb32;
	localparam logic [15:0] DRIVE_MASK_3   = 16'hfff2;
	localparam logic [15:0] DRIVE_MASK_2   = 16'hff3e;
	localparam logic [15:0] DRIVE_MASK_1   = 16'hff2e;
	localparam logic [15:0] DRIVE_MASK_0   = 16'hff3e;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic [15:0] irq_lines;
		logic        clkrun_req;
		logic        serial_irq;
		logic        inta;
		logic        intb;
		logic        intc;
		logic        card_audio_pwm;
		logic        socket0_led;
		logic        socket1_led;
		logic        socket_activity_led;
		logic        general_event_out;
		logic        ring_indicate_out;
		logic        pc_pci_dma_request;
		logic        test_observe_mux;
	} src_t;

	function automatic logic [31:0] route_mask(input logic [31:0] v);
		return v & ROUTE_WR_MASK;
	endfunction

endpackage

// *** src/pin_in_sync.sv ***
// Purpose: Two-flop synchroniser for terminal input levels
// Assumes: Inputs are asynchronous pins
// Notes: Only the second flop is visible outside
`timescale 1ns/1ns
`default_nettype none
module pin_in_sync #(
	parameter int WIDTH = 7
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // pin_in_sync
`default_nettype wire

// *** src/pin_slot.sv ***
// Purpose: Selects the source and enable for one terminal
// Assumes: Candidate index equals the select code
// Notes: Purely combinational, registered by the parent
`timescale 1ns/1ns
`default_nettype none
module pin_slot #(
	parameter logic [15:0] DRIVE_MASK = 16'hffff
) (
	input  wire logic [3:0]  sel,
	input  wire logic [15:0] cand,
	output var  logic        drv,
	output var  logic        oe
);
	always_comb begin
		oe  = DRIVE_MASK[sel];
		drv = oe & cand[sel];
	end
endmodule // pin_slot
`default_nettype wire

// *** src/multifunction_pin_router.sv ***
// Purpose: Routes internal signals onto seven multifunction terminals
// Assumes: Register port with read data one cycle after the strobe
// Notes: All state resets only on rst_b, the global reset
`timescale 1ns/1ns
`default_nettype none
module multifunction_pin_router (
	input  wire logic                         clk,
	input  wire logic                         rst_b,
	input  wire pin_router_pkg::reg_req_t     req,
	output var  logic [31:0]                  reg_rdata,
	input  wire logic                         eeprom_load_valid,
	input  wire logic [31:0]                  eeprom_load_data,
	input  wire pin_router_pkg::src_t         src,
	input  wire logic [6:0]                   pin_in,
	output var  logic [6:0]                   pin_out,
	output var  logic [6:0]                   pin_oe
);
	logic [31:0] route_q;
	logic [4:0]  gpo_q;
	logic [4:0]  gpi_data_q;
	logic [4:0]  gpi_last_q;
	logic [4:0]  gpi_sts_q;
	logic [6:0]  pin_sync;
	logic [4:0]  gpi_level;
	logic [4:0]  gpi_en;
	logic [4:0]  gpi_change;
	logic [15:0] cand [7];
	logic [6:0]  slot_drv;
	logic [6:0]  slot_oe;
	logic        wr_route;
	logic        wr_gpo;
	logic        wr_sts;
	logic [2:0]  settle_q;

	// Select fields
	logic [3:0] sel6, sel5, sel4, sel3, sel2, sel1, sel0;
	assign sel6 = route_q[27:24];
	assign sel5 = route_q[23:20];
	assign sel4 = route_q[19:16];
	assign sel3 = route_q[15:12];
	assign sel2 = route_q[11:8];
	assign sel1 = route_q[7:4];
	assign sel0 = route_q[3:0];

	assign wr_route = req.wr && (req.addr == pin_router_pkg::ROUTE_OFFSET);
	assign wr_gpo   = req.wr && (req.addr == pin_router_pkg::GPO_OFFSET);
	assign wr_sts   = req.wr && (req.addr == pin_router_pkg::GPI_STS_OFFSET);

	// Routing register, global reset only
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			route_q <= pin_router_pkg::ROUTE_RESET;
		end else if (wr_route) begin
			route_q <= pin_router_pkg::route_mask(req.wdata);
		end else if (eeprom_load_valid) begin
			route_q <= pin_router_pkg::route_mask(eeprom_load_data);
		end
	end

	// General output data
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			gpo_q <= pin_router_pkg::GPO_RESET;
		end else if (wr_gpo) begin
			gpo_q <= req.wdata[4:0];
		end
	end

	pin_in_sync #(
		.WIDTH    (7)
	) u_sync (
		.clk      (clk),
		.rst_b    (rst_b),
		.async_in (pin_in),
		.sync_out (pin_sync)
	);

	// General inputs live on terminals 0, 1, 2, 4 and 5
	assign gpi_level = {pin_sync[5], pin_sync[4], pin_sync[2:0]};
	assign gpi_en[0] = (sel0 == pin_router_pkg::CODE_GP_IN);
	assign gpi_en[1] = (sel1 == pin_router_pkg::CODE_GP_IN);
	assign gpi_en[2] = (sel2 == pin_router_pkg::CODE_GP_IN);
	assign gpi_en[3] = (sel4 == pin_router_pkg::CODE_GP_IN);
	assign gpi_en[4] = (sel5 == pin_router_pkg::CODE_GP_IN);
	assign gpi_change = gpi_en & (gpi_level ^ gpi_last_q)
		& {5{settle_q[2]}};

	// Masks first samples after reset, no false change
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			settle_q <= 3'h0;
		end else begin
			settle_q <= {settle_q[1:0], 1'b1};
		end
	end

	// Input level tracking, ignored when not routed as input
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			gpi_data_q <= 5'h00;
			gpi_last_q <= 5'h00;
		end else begin
			gpi_data_q <= gpi_en & gpi_level;
			gpi_last_q <= gpi_level;
		end
	end

	// Change status, write one to clear, set wins
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			gpi_sts_q <= pin_router_pkg::GPI_STS_RESET;
		end else begin
			gpi_sts_q <= (gpi_sts_q & ~(wr_sts ? req.wdata[4:0] : 5'h00))
				| gpi_change;
		end
	end

	// Candidate sources, index is the select code
	assign cand[6] = {src.irq_lines[15:2], src.clkrun_req, 1'b0};
	assign cand[5] = {src.irq_lines[15], src.general_event_out,
		src.socket_activity_led, src.socket0_led, 1'b0,
		src.irq_lines[10], src.irq_lines[9], src.card_audio_pwm,
		2'b00, src.irq_lines[5], src.irq_lines[4], 2'b00,
		gpo_q[4], 1'b0};
	assign cand[4] = {src.irq_lines[15], src.general_event_out,
		src.socket_activity_led, src.ring_indicate_out,
		src.irq_lines[11], 1'b0, src.irq_lines[9], src.card_audio_pwm,
		2'b00, src.irq_lines[5], src.irq_lines[4], 2'b00,
		gpo_q[3], 1'b0};
	assign cand[3] = {src.irq_lines[15:4], 2'b00, src.serial_irq,
		1'b0};
	assign cand[2] = {src.irq_lines[7], src.general_event_out,
		src.test_observe_mux, src.ring_indicate_out, src.intc,
		src.irq_lines[10], src.irq_lines[9], src.card_audio_pwm,
		2'b00, src.irq_lines[5], src.irq_lines[4], src.irq_lines[3],
		src.pc_pci_dma_request, gpo_q[2], 1'b0};
	assign cand[1] = {src.irq_lines[15], src.general_event_out,
		src.socket1_led, src.socket0_led, src.irq_lines[11],
		src.irq_lines[10], src.irq_lines[9], src.card_audio_pwm,
		2'b00, src.irq_lines[5], 1'b0, src.irq_lines[3], src.intb,
		gpo_q[1], 1'b0};
	assign cand[0] = {src.irq_lines[15], src.general_event_out,
		src.socket1_led, src.socket0_led, src.irq_lines[11],
		src.irq_lines[10], src.irq_lines[9], src.card_audio_pwm,
		2'b00, src.irq_lines[5], src.irq_lines[4], src.irq_lines[3],
		src.inta, gpo_q[0], 1'b0};

	pin_slot #(.DRIVE_MASK(pin_router_pkg::DRIVE_MASK_6)) u_slot6 (
		.sel (sel6),
		.cand(cand[6]),
		.drv (slot_drv[6]),
		.oe  (slot_oe[6])
	);
	pin_slot #(.DRIVE_MASK(pin_router_pkg::DRIVE_MASK_5)) u_slot5 (
		.sel (sel5),
		.cand(cand[5]),
		.drv (slot_drv[5]),
		.oe  (slot_oe[5])
	);
	pin_slot #(.DRIVE_MASK(pin_router_pkg::DRIVE_MASK_4)) u_slot4 (
		.sel (sel4),
		.cand(cand[4]),
		.drv (slot_drv[4]),
		.oe  (slot_oe[4])
	);
	pin_slot #(.DRIVE_MASK(pin_router_pkg::DRIVE_MASK_3)) u_slot3 (
		.sel (sel3),
		.cand(cand[3]),
		.drv (slot_drv[3]),
		.oe  (slot_oe[3])
	);
	pin_slot #(.DRIVE_MASK(pin_router_pkg::DRIVE_MASK_2)) u_slot2 (
		.sel (sel2),
		.cand(cand[2]),
		.drv (slot_drv[2]),
		.oe  (slot_oe[2])
	);
	pin_slot #(.DRIVE_MASK(pin_router_pkg::DRIVE_MASK_1)) u_slot1 (
		.sel (sel1),
		.cand(cand[1]),
		.drv (slot_drv[1]),
		.oe  (slot_oe[1])
	);
	pin_slot #(.DRIVE_MASK(pin_router_pkg::DRIVE_MASK_0)) u_slot0 (
		.sel (sel0),
		.cand(cand[0]),
		.drv (slot_drv[0]),
		.oe  (slot_oe[0])
	);

	// Registered terminal drive, reserved and input codes stay off
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pin_out <= 7'h00;
			pin_oe  <= 7'h00;
		end else begin
			pin_out <= slot_drv;
			pin_oe  <= slot_oe;
		end
	end

	// Read data for one cycle after the strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata <= 32'h0000_0000;
		end else if (!req.rd) begin
			reg_rdata <= 32'h0000_0000;
		end else if (req.addr == pin_router_pkg::ROUTE_OFFSET) begin
			reg_rdata <= pin_router_pkg::route_mask(route_q);
		end else if (req.addr == pin_router_pkg::GPI_DATA_OFFSET) begin
			reg_rdata <= {27'h0000000, gpi_data_q};
		end else if (req.addr == pin_router_pkg::GPI_STS_OFFSET) begin
			reg_rdata <= {27'h0000000, gpi_sts_q};
		end else if (req.addr == pin_router_pkg::GPO_OFFSET) begin
			reg_rdata <= {27'h0000000, gpo_q};
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	rsvd_read_zero_a: assert property (
		req.rd |=> reg_rdata[31:28] == 4'h0)
		else $error("Routing top bits read nonzero");

	route_reset_val_a: assert property (
		$rose(rst_b) |-> route_q == pin_router_pkg::ROUTE_RESET)
		else $error("Routing reset value wrong");

	route_write_a: assert property (
		wr_route |=> route_q == {4'h0, $past(req.wdata[27:0])})
		else $error("Routing write not stored");

	eeprom_preload_a: assert property (
		(eeprom_load_valid && !wr_route)
		|=> route_q == {4'h0, $past(eeprom_load_data[27:0])})
		else $error("EEPROM preload not stored");

	route_readback_a: assert property (
		(req.rd && req.addr == pin_router_pkg::ROUTE_OFFSET)
		|=> reg_rdata == $past(route_q))
		else $error("Routing readback mismatch");

	gpo_drive_pin_a: assert property (
		(sel0 == pin_router_pkg::CODE_GP_OUT)
		|=> pin_oe[0] && pin_out[0] == $past(gpo_q[0]))
		else $error("General output not driven");

	reserved_undriven_a: assert property (
		(sel6 == 4'h0) |=> !pin_oe[6] && !pin_out[6])
		else $error("Terminal 6 reserved code drives");

	pin5_reserved_a: assert property (
		(sel5 == 4'h6 || sel5 == 4'hb) |=> !pin_oe[5] && !pin_out[5])
		else $error("Terminal 5 reserved code drives");

	pin4_reserved_a: assert property (
		(sel4 == 4'h6 || sel4 == 4'ha) |=> !pin_oe[4] && !pin_out[4])
		else $error("Terminal 4 reserved code drives");

	pin3_reserved_a: assert property (
		(sel3 == 4'h0) |=> !pin_oe[3] && !pin_out[3])
		else $error("Terminal 3 reserved code drives");

	pin1_reserved_a: assert property (
		(sel1 == 4'h4 || sel1 == 4'h7) |=> !pin_oe[1] && !pin_out[1])
		else $error("Terminal 1 reserved code drives");

	pin0_reserved_a: assert property (
		(sel0 == 4'h6 || sel0 == 4'h7) |=> !pin_oe[0] && !pin_out[0])
		else $error("Terminal 0 reserved code drives");

	pin6_irq_map_a: assert property (
		(sel6 >= 4'h2) |=> pin_oe[6] &&
		pin_out[6] == $past(src.irq_lines[sel6]))
		else $error("Terminal 6 IRQ mapping wrong");

	pin3_serial_a: assert property (
		(sel3 == 4'h1) |=> pin_out[3] == $past(src.serial_irq))
		else $error("Terminal 3 serial IRQ wrong");

	pin5_audio_a: assert property (
		(sel5 == 4'h8) |=> pin_out[5] == $past(src.card_audio_pwm))
		else $error("Terminal 5 audio mapping wrong");

	pin2_dma_a: assert property (
		(sel2 == 4'h2) |=> pin_out[2] == $past(src.pc_pci_dma_request))
		else $error("Terminal 2 DMA mapping wrong");

	gpi_status_set_a: assert property (
		gpi_change[0] |=> gpi_sts_q[0] ##1 1'b1)
		else $error("Input change not flagged");

	gpi_data_track_a: assert property (
		gpi_en[1] |=> gpi_data_q[1] == $past(pin_sync[1]))
		else $error("Input level not reflected");

	pin6_clkrun_a: assert property (
		(sel6 == 4'h1) |=> pin_oe[6] &&
		pin_out[6] == $past(src.clkrun_req))
		else $error("Terminal 6 clock-run mapping wrong");

	pin5_event_a: assert property (
		(sel5 == 4'he) |=> pin_oe[5] &&
		pin_out[5] == $past(src.general_event_out))
		else $error("Terminal 5 event mapping wrong");

	pin4_ring_a: assert property (
		(sel4 == 4'hc) |=> pin_oe[4] &&
		pin_out[4] == $past(src.ring_indicate_out))
		else $error("Terminal 4 ring mapping wrong");

	pin4_activity_a: assert property (
		(sel4 == 4'hd) |=> pin_oe[4] &&
		pin_out[4] == $past(src.socket_activity_led))
		else $error("Terminal 4 activity LED wrong");

	pin3_irq_map_a: assert property (
		(sel3 >= 4'h4) |=> pin_oe[3] &&
		pin_out[3] == $past(src.irq_lines[sel3]))
		else $error("Terminal 3 IRQ mapping wrong");

	pin2_irq7_a: assert property (
		(sel2 == 4'hf) |=> pin_oe[2] &&
		pin_out[2] == $past(src.irq_lines[7]))
		else $error("Terminal 2 IRQ7 mapping wrong");

	pin1_intb_a: assert property (
		(sel1 == 4'h2) |=> pin_oe[1] &&
		pin_out[1] == $past(src.intb))
		else $error("Terminal 1 INTB mapping wrong");

	pin0_inta_a: assert property (
		(sel0 == 4'h2) |=> pin_oe[0] &&
		pin_out[0] == $past(src.inta))
		else $error("Terminal 0 INTA mapping wrong");

	gpo_drive_pin5_a: assert property (
		(sel5 == pin_router_pkg::CODE_GP_OUT) |=> pin_oe[5] &&
		pin_out[5] == $past(gpo_q[4]))
		else $error("Terminal 5 general output wrong");

	gpi_ignored_a: assert property (
		(sel0 != pin_router_pkg::CODE_GP_IN) |=> !gpi_data_q[0])
		else $error("Unrouted input level seen");

	route_hold_a: assert property (
		(!wr_route && !eeprom_load_valid) |=> $stable(route_q))
		else $error("Routing changed without a write");

	gpi_status_clear_a: assert property (
		(wr_sts && req.wdata[0] && !gpi_change[0]) |=> !gpi_sts_q[0])
		else $error("Input status not cleared");

	route_write_c: cover property (wr_route ##1 req.rd);
	eeprom_load_c: cover property (eeprom_load_valid);
	gpi_change_c: cover property (gpi_change != 5'h00 ##1 wr_sts);
	pin_reserved_c: cover property (sel5 == 4'h6 && !pin_oe[5]);
	gpo_drive_c: cover property (sel0 == 4'h1 ##1 pin_oe[0]);
endmodule // multifunction_pin_router
`default_nettype wire

// *** bench/board_model.sv ***
// Purpose: Board circuitry on the far side of the seven terminals
// Assumes: Board drives a level onto every terminal the router releases
// Notes: Router output wins wherever its enable is high
`timescale 1ns/1ns
`default_nettype none
module board_model (
	input  wire logic [6:0] ext_lvl,
	input  wire logic [6:0] pin_out,
	input  wire logic [6:0] pin_oe,
	output wire logic [6:0] pin_in
);
	// Wire level from both drivers
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // board_model
`default_nettype wire

// *** bench/tb.sv ***
// Purpose: Self-checking bench for the multifunction pin router
// Assumes: Read data stands one cycle after the read strobe
// Notes: Reference model built from the routing code tables
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module tb;
	logic                     clk;
	logic                     rst_b;
	pin_router_pkg::reg_req_t req;
	logic [31:0]              reg_rdata;
	logic                     ld_v;
	logic [31:0]              ld_d;
	pin_router_pkg::src_t     src;
	logic [6:0]               pin_in;
	logic [6:0]               pin_out;
	logic [6:0]               pin_oe;
	logic [6:0]               ext_lvl;
	logic [6:0]               prev;
	logic [31:0]              rdv;
	logic [31:0]              route;
	logic [4:0]               gpo;
	int                       fails;
	int                       num_checks;
	int                       seed;

	multifunction_pin_router uut (.clk(clk), .rst_b(rst_b), .req(req),
		.reg_rdata(reg_rdata), .eeprom_load_valid(ld_v),
		.eeprom_load_data(ld_d), .src(src), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe));
	board_model board (.ext_lvl(ext_lvl), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_in(pin_in));

	// Expected {enable, level} of terminal t under code c
	function automatic logic [1:0] mdl(int t, int c,
		pin_router_pkg::src_t s, logic [4:0] g);
		logic [15:0] q;
		q = s.irq_lines;
		if (t == 6)
			return (c == 0) ? 2'h0 : {1'b1, (c == 1) ? s.clkrun_req : q[c]};
		if (t == 3)
			return (c > 3) ? {1'b1, q[c]} :
				(c == 1) ? {1'b1, s.serial_irq} : 2'h0;
		case (c)
		0, 6, 7: return 2'h0;
		1: return {1'b1, g[(t > 3) ? t - 1 : t]};
		2: return (t == 0) ? {1'b1, s.inta} : (t == 1) ? {1'b1, s.intb} :
			(t == 2) ? {1'b1, s.pc_pci_dma_request} : 2'h0;
		3: return (t < 3) ? {1'b1, q[3]} : 2'h0;
		4: return (t == 1) ? 2'h0 : {1'b1, q[4]};
		8: return {1'b1, s.card_audio_pwm};
		10: return (t == 4) ? 2'h0 : {1'b1, q[10]};
		11: return (t == 5) ? 2'h0 : {1'b1, (t == 2) ? s.intc : q[11]};
		12: return {1'b1, (t == 2 || t == 4) ? s.ring_indicate_out :
			s.socket0_led};
		13: return {1'b1, (t == 2) ? s.test_observe_mux :
			(t > 3) ? s.socket_activity_led : s.socket1_led};
		14: return {1'b1, s.general_event_out};
		15: return {1'b1, (t == 2) ? q[7] : q[15]};
		default: return {1'b1, q[c]};
		endcase
	endfunction

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	task automatic rdr(logic [7:0] a);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1 rdv = reg_rdata;
	endtask

	// New random sources, then all terminals against the model
	task automatic pins();
		@(posedge clk);
		src <= 29'($random(seed));
		repeat (3) @(posedge clk);
		#1;
		for (int t = 0; t < 7; t++) begin
			`CHK("pin", mdl(t, route[4*t +: 4], src, gpo), {pin_oe[t], pin_out[t]})
		end
	endtask

	task automatic final_report();
		if (fails == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		#20000;
		fails++;
		final_report();
	end

	initial begin
		seed = 73;
		fails = 0;
		num_checks = 0;
		rst_b = 1'b0;
		req = '0;
		ld_v = 1'b0;
		ld_d = '0;
		src = '0;
		ext_lvl = '0;
		gpo = '0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		route = pin_router_pkg::ROUTE_RESET;
		rdr(8'h8c); `CHK("route", 32'h0000_1000, rdv)
		pins();
		for (int i = 0; i < 32; i++) begin
			gpo = 5'($random(seed));
			wr(pin_router_pkg::GPO_OFFSET, {27'h0, gpo});
			rdr(pin_router_pkg::GPO_OFFSET); `CHK("gpo", {27'h0, gpo}, rdv)
			route = (i < 16) ? {4'h0, {7{4'(i)}}} : {4'h0, 28'($random(seed))};
			wr(8'h8c, route | 32'hf000_0000);
			rdr(8'h8c); `CHK("route", route, rdv)
			repeat (2) pins();
		end
		@(posedge clk);
		ld_d <= $random(seed);
		ld_v <= 1'b1;
		@(posedge clk);
		ld_v <= 1'b0;
		route = {4'h0, ld_d[27:0]};
		rdr(8'h8c); `CHK("preload", route, rdv)
		pins();
		@(posedge clk);
		req <= '{addr: 8'h8c, wdata: 32'h0123_4567, wr: 1'b1, rd: 1'b0};
		ld_v <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
		ld_v <= 1'b0;
		rdr(8'h8c); `CHK("route", 32'h0123_4567, rdv)
		ext_lvl <= 7'($random(seed));
		wr(8'h8c, 32'h0);
		route = '0;
		repeat (6) @(posedge clk);
		wr(pin_router_pkg::GPI_STS_OFFSET, 32'h1f);
		rdr(pin_router_pkg::GPI_STS_OFFSET); `CHK("status", 32'h0, rdv)
		prev = ext_lvl;
		ext_lvl <= ~prev;
		repeat (6) @(posedge clk);
		rdr(pin_router_pkg::GPI_DATA_OFFSET); `CHK("gpi", {27'h0, ~prev[5:4], ~prev[2:0]}, rdv)
		rdr(pin_router_pkg::GPI_STS_OFFSET); `CHK("status", 32'h1f, rdv)
		wr(8'h8c, 32'h0111_1111);
		repeat (4) @(posedge clk);
		rdr(pin_router_pkg::GPI_DATA_OFFSET); `CHK("gpi", 32'h0, rdv)
		rdr(8'h00); `CHK("unmapped", 32'h0, rdv)
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		route = pin_router_pkg::ROUTE_RESET;
		gpo = '0;
		rdr(8'h8c); `CHK("route", 32'h0000_1000, rdv)
		rdr(pin_router_pkg::GPI_STS_OFFSET);
		`CHK("status", 32'h0, rdv)
		rdr(pin_router_pkg::GPI_DATA_OFFSET);
		`CHK("gpi", {27'h0, ~prev[5:4], ~prev[2:0]}, rdv)
		pins();
		final_report();
	end
endmodule // tb
`default_nettype wire
